// ### pfm_cfg.svh
// Constants of the program flash access control block.
// Assumes a 200 MHz system clock and an 8-bit special function register port.
`ifndef PFM_CFG_SVH
`define PFM_CFG_SVH

// Register select codes
`define SEL_DATA_LOW      3'h0
`define SEL_DATA_HIGH     3'h1
`define SEL_ADDRESS_LOW   3'h2
`define SEL_ADDRESS_HIGH  3'h3
`define SEL_CONTROL       3'h4
`define SEL_UNLOCK_KEY    3'h5

// Control register fields
`define CTL_RD_BIT        0
`define CTL_WR_BIT        1
`define CTL_WRITE_ALLOW_BIT      2
`define CTL_CAL_BIT       6
`define CTL_FIXED_ONE     8'h80
`define CTL_RESET         8'h80

// Implemented bits and reset values
`define DATA_HIGH_MASK    8'h3F
`define ADDRESS_HIGH_MASK 8'h0F
`define REG_RESET         8'h00
`define BYTE_ZERO         8'h00

// Unlock keys and key stages
`define KEY_FIRST         8'h55
`define KEY_SECOND        8'hAA
`define STAGE_NONE        2'h0
`define STAGE_FIRST       2'h1
`define STAGE_ARMED       2'h2

// Block geometry
`define LAST_WORD         2'h3
`define FIRST_WORD        2'h0
`define ROW_BASE_LOW      4'h0
`define SETUP_LAST        2'h1

// Block write protect limits (exclusive upper bound of protected span)
`define WP_NONE           2'h3
`define WP_SMALL          2'h2
`define WP_HALF           2'h1
`define WP_LIMIT_SMALL    13'h0400
`define WP_LIMIT_HALF     13'h0800
`define WP_LIMIT_ALL      13'h1000

// Timing
`define CLK_MHZ           200
`define ERASE_TIME_US     4000
`define PROG_TIME_NS      2000
`define NS_PER_US         1000

`endif

// ### pfm_pkg.sv
// Types shared by the program flash access control block.
// Assumes pfm_cfg.svh sits in the include path.
`include "pfm_cfg.svh"

package pfm_pkg;

   // Register select on the special function register port
   typedef enum logic [2:0] {
      SEL_DATA_LOW     = `SEL_DATA_LOW,
      SEL_DATA_HIGH    = `SEL_DATA_HIGH,
      SEL_ADDRESS_LOW  = `SEL_ADDRESS_LOW,
      SEL_ADDRESS_HIGH = `SEL_ADDRESS_HIGH,
      SEL_CONTROL      = `SEL_CONTROL,
      SEL_UNLOCK_KEY   = `SEL_UNLOCK_KEY
   } sfr_sel_e;

   // Sequencer states, Gray coded in the order listed
   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_RD_WAIT   = 3'b001,
      ST_RD_ACCESS = 3'b011,
      ST_WR_SETUP  = 3'b010,
      ST_ERASE     = 3'b110,
      ST_PROGRAM   = 3'b111,
      ST_DONE      = 3'b101
   } fsm_e;

   // Request to the flash array
   typedef struct packed {
      logic        rd;
      logic        cal;
      logic        erase;
      logic        prog;
      logic [12:0] addr;
      logic [13:0] data;
   } flash_req_s;

endpackage : pfm_pkg

// ### pfm_word_buffer.sv
// Four-word write buffer loaded before a block program.
// Assumes writes and reads come from the sequencer in the same clock domain.
`timescale 1ns/1ps

module pfm_word_buffer (
   // Clock
   input  wire logic        clk,
   // Load side
   input  wire logic        wr_en,
   input  wire logic [1:0]  wr_idx,
   input  wire logic [13:0] wr_data,
   // Drain side
   input  wire logic [1:0]  rd_idx,
   output logic [13:0]      rd_data
);

   logic [13:0] words [4];

   // Store one word at its position in the block
   always_ff @(posedge clk) begin
      if (wr_en) begin
         words[wr_idx] <= wr_data;
      end
   end

   // Word currently being programmed
   assign rd_data = words[rd_idx];

endmodule : pfm_word_buffer

// ### pfm_op_timer.sv
// Down counter that times erase and program pulses.
// Assumes load is a one-cycle pulse; done is a one-cycle pulse at expiry.
`timescale 1ns/1ps

module pfm_op_timer (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Control
   input  wire logic        load,
   input  wire logic [19:0] load_value,
   output logic             done
);

   logic [19:0] count;

   // Count down to zero after a load
   always_ff @(posedge clk) begin
      if (srst) begin
         count <= '0;
         done  <= 1'b0;
      end else begin
         done <= (count == 20'h0_0001) && !load;
         if (load) begin
            count <= load_value;
         end else if (count != 20'h0_0000) begin
            count <= count - 20'h0_0001;
         end
      end
   end

endmodule : pfm_op_timer

// ### program_flash_access_control.sv
// Program flash access control: registers, unlock and read/erase/program sequencer.
// Assumes INSTR_CE pulses once per instruction cycle, at least two clocks apart,
// and that the flash array returns read data one clock after its read request.
//
// Function
// - data bytes form a 14-bit word, address bytes a 13-bit address
// - 4K words of program flash at 0000h to 0FFFh are reachable
// - reads move one word, writes move a block of four words
// - the last word of a block erases the row, then programs
// - erase and program durations come from an internal timer
// - code protection does not stop reads or writes from this block
// - writes into protected regions are blocked, reads are always allowed
// - code protection shuts the serial programmer out of all memory
// - read and write triggers are set only by software, cleared by hardware
// - write-allow bit 2 gates writes and clears at reset
// - calibration select bit 6 steers reads and blocks all writes
// - unlock key port has no storage and reads zero
// - data high holds six bits, bits 7 and 6 read zero
// - address high holds four bits, bits 7 to 4 read zero
// - control bit 7 reads one, bits 5 to 3 read zero
// - read trigger starts a one-cycle read, then clears
// - write trigger reads one until the write has finished
// - flash is read in the second instruction cycle, which is ignored
// - first three words only load the buffer, the fourth erases and programs
// - CPU halts during erase and program while clocks keep running
`timescale 1ns/1ps

module program_flash_access_control
   import pfm_pkg::*;
#(
   parameter int unsigned ERASE_CYCLES = `ERASE_TIME_US * `CLK_MHZ
) (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        SRST,
   // Instruction cycle
   input  wire logic        INSTR_CE,
   // Special function register port
   input  wire sfr_sel_e    SFR_SEL,
   input  wire logic        SFR_WR,
   input  wire logic [7:0]  SFR_WDATA,
   output logic [7:0]       SFR_RDATA,
   // Configuration word
   input  wire logic        CODE_PROTECT,
   input  wire logic [1:0]  BLOCK_WRITE_PROTECT,
   // Serial programmer gate
   output logic             PROG_PORT_ALLOW,
   // CPU control
   output logic             CPU_HALT,
   output logic             INSTR_IGNORE,
   // Flash array
   output flash_req_s       FLASH_REQ,
   input  wire logic [13:0] FLASH_RDATA
);

   localparam logic [19:0] ERASE_LOAD = 20'(ERASE_CYCLES);
   localparam logic [19:0] PROG_LOAD  = 20'((`PROG_TIME_NS * `CLK_MHZ) / `NS_PER_US);

   // True when the address lies in a region the protect setting covers
   function automatic logic wp_blocked(input logic [12:0] addr, input logic [1:0] wrt);
      logic [12:0] limit;
      limit = (wrt == `WP_SMALL) ? `WP_LIMIT_SMALL :
              (wrt == `WP_HALF)  ? `WP_LIMIT_HALF  : `WP_LIMIT_ALL;
      return (wrt != `WP_NONE) && (addr < limit);
   endfunction : wp_blocked

   logic [7:0]  data_low;
   logic [5:0]  data_high;
   logic [7:0]  address_low;
   logic [3:0]  address_high;
   logic        ctl_rd;
   logic        ctl_wr;
   logic        write_allow;
   logic        calibration_space_select;
   logic [1:0]  key_stage;
   fsm_e        state;
   fsm_e        next_state;
   logic [1:0]  instr_cnt;
   logic [1:0]  next_instr_cnt;
   logic [1:0]  word;
   logic [1:0]  next_word;
   logic        rd_capture;
   logic        timer_load;
   logic [19:0] timer_value;
   logic        timer_done;
   logic [13:0] buf_rd_data;
   flash_req_s  next_req;
   logic [1:0]  next_key_stage;

   // Register port decode
   wire         wr_data_low     = SFR_WR && (SFR_SEL == SEL_DATA_LOW);
   wire         wr_data_high    = SFR_WR && (SFR_SEL == SEL_DATA_HIGH);
   wire         wr_address_low  = SFR_WR && (SFR_SEL == SEL_ADDRESS_LOW);
   wire         wr_address_high = SFR_WR && (SFR_SEL == SEL_ADDRESS_HIGH);
   wire         wr_control      = SFR_WR && (SFR_SEL == SEL_CONTROL);
   wire         wr_key          = SFR_WR && (SFR_SEL == SEL_UNLOCK_KEY);

   // Joined word and address; top address bit is always zero
   wire [13:0]  data_word = {data_high, data_low};
   wire [12:0]  flash_word_addr = {1'b0, address_high, address_low};
   wire [1:0]   word_idx = address_low[1:0];
   wire         last_word = (word_idx == `LAST_WORD);

   // Trigger qualification
   wire         seq_idle = (state == ST_IDLE) && !ctl_rd && !ctl_wr;
   wire         write_ok = (key_stage == `STAGE_ARMED)
                           && SFR_WDATA[`CTL_WRITE_ALLOW_BIT]
                           && !SFR_WDATA[`CTL_CAL_BIT]
                           && !wp_blocked(flash_word_addr, BLOCK_WRITE_PROTECT);
   wire         start_write = wr_control && SFR_WDATA[`CTL_WR_BIT] && seq_idle && write_ok;
   wire         start_read  = wr_control && SFR_WDATA[`CTL_RD_BIT] && seq_idle && !start_write;

   // Serial programmer is shut out while code protected
   assign PROG_PORT_ALLOW = !CODE_PROTECT;

   // CPU status from the sequencer state
   assign CPU_HALT     = (state == ST_ERASE) || (state == ST_PROGRAM);
   assign INSTR_IGNORE = (state == ST_RD_ACCESS);

   // Unlock key tracking: any other register write breaks the sequence
   always_comb begin
      next_key_stage = key_stage;
      if (wr_key) begin
         if (SFR_WDATA == `KEY_FIRST) begin
            next_key_stage = `STAGE_FIRST;
         end else if (SFR_WDATA == `KEY_SECOND && key_stage == `STAGE_FIRST) begin
            next_key_stage = `STAGE_ARMED;
         end else begin
            next_key_stage = `STAGE_NONE;
         end
      end else if (SFR_WR) begin
         next_key_stage = `STAGE_NONE;
      end
   end

   // Sequencer next state and flash requests
   always_comb begin
      next_state     = state;
      next_instr_cnt = instr_cnt;
      next_word      = word;
      timer_load     = 1'b0;
      timer_value    = PROG_LOAD;
      next_req       = '0;
      next_req.cal   = calibration_space_select;
      next_req.addr  = flash_word_addr;
      case (state)
         ST_IDLE: begin
            next_instr_cnt = '0;
            if (start_write) begin
               next_state = ST_WR_SETUP;
            end else if (start_read) begin
               next_state = ST_RD_WAIT;
            end
         end
         ST_RD_WAIT: begin
            if (INSTR_CE) begin
               next_state  = ST_RD_ACCESS;
               next_req.rd = 1'b1;
            end
         end
         ST_RD_ACCESS: begin
            if (INSTR_CE && !FLASH_REQ.rd && !rd_capture) begin
               next_state = ST_DONE;
            end
         end
         ST_WR_SETUP: begin
            if (INSTR_CE) begin
               next_instr_cnt = instr_cnt + 2'h1;
               if (instr_cnt == `SETUP_LAST) begin
                  if (last_word) begin
                     next_state         = ST_ERASE;
                     next_req.erase     = 1'b1;
                     next_req.addr[3:0] = `ROW_BASE_LOW;
                     timer_load         = 1'b1;
                     timer_value        = ERASE_LOAD;
                  end else begin
                     next_state = ST_DONE;
                  end
               end
            end
         end
         ST_ERASE: begin
            if (timer_done) begin
               next_state         = ST_PROGRAM;
               next_word          = `FIRST_WORD;
               next_req.prog      = 1'b1;
               next_req.addr[1:0] = `FIRST_WORD;
               timer_load         = 1'b1;
            end
         end
         ST_PROGRAM: begin
            if (timer_done) begin
               if (word == `LAST_WORD) begin
                  next_state = ST_DONE;
               end else begin
                  next_word          = word + 2'h1;
                  next_req.prog      = 1'b1;
                  next_req.addr[1:0] = word + 2'h1;
                  timer_load         = 1'b1;
               end
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Write buffer, loaded by each accepted write trigger
   pfm_word_buffer u_buffer (
      .clk     (CLK_SYS),
      .wr_en   (start_write),
      .wr_idx  (word_idx),
      .wr_data (data_word),
      .rd_idx  (next_word),
      .rd_data (buf_rd_data)
   );

   // Erase and program timer
   pfm_op_timer u_timer (
      .clk        (CLK_SYS),
      .srst       (SRST),
      .load       (timer_load),
      .load_value (timer_value),
      .done       (timer_done)
   );

   // Sequencer registers and flash request
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         state      <= ST_IDLE;
         instr_cnt  <= '0;
         word       <= '0;
         rd_capture <= 1'b0;
         FLASH_REQ  <= '0;
         key_stage  <= `STAGE_NONE;
      end else begin
         state          <= next_state;
         instr_cnt      <= next_instr_cnt;
         word           <= next_word;
         rd_capture     <= FLASH_REQ.rd;
         FLASH_REQ      <= next_req;
         FLASH_REQ.data <= buf_rd_data;
         key_stage      <= next_key_stage;
      end
   end

   // Data registers: flash read capture wins over a software write
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         data_low  <= `REG_RESET;
         data_high <= '0;
      end else if (rd_capture) begin
         data_low  <= FLASH_RDATA[7:0];
         data_high <= FLASH_RDATA[13:8];
      end else begin
         if (wr_data_low)  data_low  <= SFR_WDATA;
         if (wr_data_high) data_high <= SFR_WDATA[5:0];
      end
   end

   // Address registers
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         address_low  <= `REG_RESET;
         address_high <= '0;
      end else begin
         if (wr_address_low)  address_low  <= SFR_WDATA;
         if (wr_address_high) address_high <= SFR_WDATA[3:0];
      end
   end

   // Control register: triggers set by software, cleared by hardware only
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ctl_rd                   <= 1'b0;
         ctl_wr                   <= 1'b0;
         write_allow              <= 1'b0;
         calibration_space_select <= 1'b0;
      end else begin
         if (start_read) begin
            ctl_rd <= 1'b1;
         end else if (state == ST_DONE) begin
            ctl_rd <= 1'b0;
         end
         if (start_write) begin
            ctl_wr <= 1'b1;
         end else if (state == ST_DONE) begin
            ctl_wr <= 1'b0;
         end
         if (wr_control) begin
            write_allow              <= SFR_WDATA[`CTL_WRITE_ALLOW_BIT];
            calibration_space_select <= SFR_WDATA[`CTL_CAL_BIT];
         end
      end
   end

   // Read data mux, registered
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         SFR_RDATA <= `BYTE_ZERO;
      end else if (SFR_SEL == SEL_DATA_LOW) begin
         SFR_RDATA <= data_low;
      end else if (SFR_SEL == SEL_DATA_HIGH) begin
         SFR_RDATA <= {2'b00, data_high};
      end else if (SFR_SEL == SEL_ADDRESS_LOW) begin
         SFR_RDATA <= address_low;
      end else if (SFR_SEL == SEL_ADDRESS_HIGH) begin
         SFR_RDATA <= {4'h0, address_high};
      end else if (SFR_SEL == SEL_CONTROL) begin
         SFR_RDATA <= `CTL_FIXED_ONE | {1'b0, calibration_space_select, 3'b000,
                                        write_allow, ctl_wr, ctl_rd};
      end else begin
         SFR_RDATA <= `BYTE_ZERO;
      end
   end

   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   read_capture_a: assert property (FLASH_REQ.rd |=> ##1 {data_high, data_low} == $past(FLASH_RDATA))
      else $error("flash read data not captured");
   key_order_a: assert property ($rose(ctl_wr) |-> $past(key_stage) == `STAGE_ARMED)
      else $error("write started without unlock keys");
   write_allow_a: assert property ($rose(ctl_wr) |-> write_allow)
      else $error("write started with write-allow low");
   cal_block_a: assert property ($rose(ctl_wr) |-> !calibration_space_select)
      else $error("write started with calibration select set");
   key_reads_zero_a: assert property (SFR_SEL == SEL_UNLOCK_KEY |=> SFR_RDATA == `BYTE_ZERO)
      else $error("key port read non-zero");
   control_fixed_a: assert property (SFR_SEL == SEL_CONTROL |=> SFR_RDATA[7] && SFR_RDATA[5:3] == 3'b000)
      else $error("control unimplemented bits wrong");
   data_high_zero_a: assert property (SFR_SEL == SEL_DATA_HIGH |=> SFR_RDATA[7:6] == 2'b00)
      else $error("data high upper bits non-zero");
   address_high_zero_a: assert property (SFR_SEL == SEL_ADDRESS_HIGH |=> SFR_RDATA[7:4] == 4'h0)
      else $error("address high upper bits non-zero");
   erase_halts_a: assert property (FLASH_REQ.erase |-> CPU_HALT [*8])
      else $error("cpu not halted during erase");
   erase_protect_a: assert property (FLASH_REQ.erase |-> !wp_blocked(FLASH_REQ.addr, BLOCK_WRITE_PROTECT))
      else $error("erase inside protected region");
   wr_sticky_a: assert property (ctl_wr && state != ST_DONE |=> ctl_wr)
      else $error("write trigger cleared early");

   read_done_c: cover property (rd_capture ##[1:20] $fell(ctl_rd));
   buffer_load_c: cover property ($rose(ctl_wr) && !last_word);
   block_program_c: cover property (FLASH_REQ.prog && FLASH_REQ.addr[1:0] == `LAST_WORD);
   key_break_c: cover property (key_stage == `STAGE_FIRST ##1 key_stage == `STAGE_NONE);

endmodule : program_flash_access_control

// ### pfm_flash_model.sv
// Behavioural model of the program flash array behind the access block.
// Assumes one request per clock; read data comes back one clock later.
`timescale 1ns/1ps

module pfm_flash_model
   import pfm_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // Request and answer
   input  wire flash_req_s  req,
   output logic [13:0]      rdata
);
   logic [13:0] mem [0:4095];
   logic [13:0] cal [0:15];
   int          prog_cnt;

   // Preload with an address-dependent pattern
   initial begin
      rdata = 14'h0000;
      prog_cnt = 0;
      for (int i = 0; i < 4096; i++) mem[i] = 14'(i) ^ 14'h1555;
      for (int i = 0; i < 16; i++) cal[i] = 14'h2000 | 14'(i);
   end

   // Read a clock later, row erase, word program
   always @(posedge clk) begin
      if (req.rd)
         rdata <= req.cal ? cal[req.addr[3:0]] : mem[req.addr[11:0]];
      else
         rdata <= ~rdata; // Not held outside a read
      if (req.erase)
         for (int i = 0; i < 16; i++) mem[{req.addr[11:4], 4'(i)}] <= 14'h3FFF;
      if (req.prog) begin
         mem[req.addr[11:0]] <= req.data;
         prog_cnt <= prog_cnt + 1;
      end
   end
endmodule : pfm_flash_model

// ### program_flash_access_control_tb.sv
// Self-checking testbench of the program flash access control block.
// Assumes the package, design files and flash model are compiled first.
`timescale 1ns/1ps

module program_flash_access_control_tb;
   import pfm_pkg::*;

   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        instr_ce = 1'b0;
   sfr_sel_e    sfr_sel = SEL_DATA_LOW;
   logic        sfr_wr = 1'b0;
   logic [7:0]  sfr_wdata = 8'h00;
   logic [7:0]  sfr_rdata;
   logic        code_protect = 1'b0;
   logic [1:0]  block_wp = 2'h3;
   logic        prog_allow, cpu_halt, instr_ignore, halt_seen, ign_seen;
   flash_req_s  flash_req;
   logic [13:0] flash_rdata;
   logic [1:0]  ce_cnt = 2'h0;
   logic [7:0]  v;
   int          error_cnt = 0;
   int          checked = 0;
   int          halt_cnt = 0;
   sfr_sel_e    sels [6] = '{SEL_DATA_LOW, SEL_DATA_HIGH, SEL_ADDRESS_LOW,
                             SEL_ADDRESS_HIGH, SEL_CONTROL, SEL_UNLOCK_KEY};
   logic [7:0]  rst_exp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
   logic [7:0]  wr_val [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFC, 8'hFF};
   logic [7:0]  wr_exp [6] = '{8'hFF, 8'h3F, 8'hFF, 8'h0F, 8'hC4, 8'h00};
   logic [12:0] ra [6] = '{13'h0C0B, 13'h0C0B, 13'h0C0B, 13'h0103, 13'h0703, 13'h0F03};
   logic [7:0]  rc [6] = '{8'h02, 8'h46, 8'h06, 8'h06, 8'h06, 8'h06};
   logic [1:0]  rw [6] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0};

   program_flash_access_control #(.ERASE_CYCLES(20)) uut (
      .CLK_SYS(clk), .SRST(srst), .INSTR_CE(instr_ce), .SFR_SEL(sfr_sel),
      .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
      .CODE_PROTECT(code_protect), .BLOCK_WRITE_PROTECT(block_wp),
      .PROG_PORT_ALLOW(prog_allow), .CPU_HALT(cpu_halt), .INSTR_IGNORE(instr_ignore),
      .FLASH_REQ(flash_req), .FLASH_RDATA(flash_rdata));

   pfm_flash_model fm (.clk(clk), .req(flash_req), .rdata(flash_rdata));

   // Clock, instruction-cycle pulses every fourth clock, halt monitor
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      #1;
      ce_cnt = ce_cnt + 2'h1;
      instr_ce = (ce_cnt == 2'h0);
   end
   always @(negedge clk) begin
      if (cpu_halt === 1'b1) begin
         halt_seen = 1'b1;
         halt_cnt++;
      end
      if (instr_ignore === 1'b1) ign_seen = 1'b1;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Register access, entered one step after an edge
   task automatic wr_reg(input sfr_sel_e s, input logic [7:0] d);
      sfr_sel = s;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk);
      #1 sfr_wr = 1'b0;
      @(posedge clk);
      #1;
   endtask : wr_reg

   task automatic rd_reg(input sfr_sel_e s, output logic [7:0] d);
      sfr_sel = s;
      @(posedge clk);
      #1 d = sfr_rdata;
   endtask : rd_reg

   task automatic wait_clear(input int b);
      logic [7:0] c;
      c = 8'hFF;
      for (int n = 0; n < 2000 && c[b] !== 1'b0; n++) rd_reg(SEL_CONTROL, c);
      chk("trigger_clear", 16'(c[b]), 16'h0000);
   endtask : wait_clear

   task automatic rd_word(input logic [12:0] a, input logic [7:0] ctl, input logic [13:0] e);
      logic [7:0] lo, hi;
      wr_reg(SEL_ADDRESS_HIGH, {3'h0, a[12:8]});
      wr_reg(SEL_ADDRESS_LOW, a[7:0]);
      ign_seen = 1'b0;
      wr_reg(SEL_CONTROL, ctl);
      rd_reg(SEL_CONTROL, lo);
      chk("read_busy", 16'(lo), 16'(ctl | 8'h81));
      wait_clear(0);
      chk("ignore_seen", 16'(ign_seen), 16'h0001);
      rd_reg(SEL_DATA_LOW, lo);
      rd_reg(SEL_DATA_HIGH, hi);
      chk("read_word", {hi, lo}, {2'h0, e});
   endtask : rd_word

   task automatic wr_word(input logic [12:0] a, input logic [13:0] d, input logic [7:0] ctl,
                          input logic brk, input logic ok);
      logic [7:0] c;
      wr_reg(SEL_ADDRESS_HIGH, {3'h0, a[12:8]});
      wr_reg(SEL_ADDRESS_LOW, a[7:0]);
      wr_reg(SEL_DATA_LOW, d[7:0]);
      wr_reg(SEL_DATA_HIGH, {2'h0, d[13:8]});
      wr_reg(SEL_UNLOCK_KEY, 8'h55);
      if (brk) wr_reg(SEL_DATA_LOW, d[7:0]);
      wr_reg(SEL_UNLOCK_KEY, 8'hAA);
      wr_reg(SEL_CONTROL, ctl);
      rd_reg(SEL_CONTROL, c);
      chk("write_busy", 16'(c[1]), 16'(ok));
      wait_clear(1);
   endtask : wr_word

   task automatic print_verdict;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // Watchdog against a hung sequence
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      print_verdict();
   end

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      #1 srst = 1'b0;
      foreach (sels[i]) begin
         rd_reg(sels[i], v);
         chk("reset_value", 16'(v), 16'(rst_exp[i]));
      end
      foreach (sels[i]) wr_reg(sels[i], wr_val[i]);
      foreach (sels[i]) begin
         rd_reg(sels[i], v);
         chk("masked_bits", 16'(v), 16'(wr_exp[i]));
      end
      wr_reg(SEL_CONTROL, 8'h00);
      chk("prog_port_open", 16'(prog_allow), 16'h0001);
      code_protect = 1'b1;
      rd_word(13'h0FFF, 8'h01, 14'h0FFF ^ 14'h1555);
      chk("prog_port_shut", 16'(prog_allow), 16'h0000);
      rd_word(13'h0003, 8'h41, 14'h2003);
      wr_reg(SEL_CONTROL, 8'h00);
      block_wp = 2'h2;
      rd_word(13'h0100, 8'h01, 14'h0100 ^ 14'h1555);
      halt_cnt = 0;
      for (int i = 0; i < 4; i++) begin
         halt_seen = 1'b0;
         wr_word(13'h0C04 + 13'(i), 14'h2A50 + 14'(i), 8'h06, 1'b0, 1'b1);
         chk("halt_on_last", 16'(halt_seen), 16'(i == 3));
      end
      chk("halt_span", 16'(halt_cnt >= 1620 && halt_cnt <= 1630), 16'h0001);
      for (int i = 0; i < 4; i++)
         chk("programmed", fm.mem[12'hC04 + 12'(i)], 14'h2A50 + 14'(i));
      chk("row_erased", fm.mem[12'hC00], 14'h3FFF);
      foreach (ra[i]) begin
         block_wp = rw[i];
         wr_word(ra[i], 14'h1234, rc[i], i == 2, 1'b0);
      end
      chk("prog_count", 16'(fm.prog_cnt), 16'h0004);
      print_verdict();
   end
endmodule : program_flash_access_control_tb
